// ===== design/ugc_pkg.sv
// Purpose: shared constants and carrier types for the USB general control block
// Assumes: single 100 MHz clock domain
// Notes: sizes are in bytes
package ugc_pkg;
	localparam int NUM_ENTRIES = 7;
	localparam int MEM_BYTES = 832;
	localparam int BIG_ENTRY_BYTES = 256;
	localparam int SMALL_ENTRY_BYTES = 64;
	localparam int ADDR_W = 10;
	localparam int SIZE_W = 9;
	localparam logic CTRL_ENABLE_RST = 1'b0;
	localparam logic CTRL_FREEZE_RST = 1'b1;
	localparam logic CTRL_HOST_RST = 1'b0;
	localparam logic [ADDR_W-1:0] BASE_RST = 10'h000;
	localparam int GEN_SRC_N = 8;
	// Bit positions of the general event sources
	localparam int EV_ID = 0;
	localparam int EV_SUPPLY = 1;
	localparam int EV_SESSION = 2;
	localparam int EV_SWAP = 3;
	localparam int EV_SUPPLY_DROP = 4;
	localparam int EV_BCONN_ERR = 5;
	localparam int EV_NEG_ERR = 6;
	localparam int EV_SUSP_TO = 7;
	localparam logic [GEN_SRC_N-1:0] PROCESSING_MASK = 8'h0F;
	localparam logic [GEN_SRC_N-1:0] EXCEPTION_MASK = 8'hF0;
	typedef enum logic [1:0] {UGC_RESET, UGC_DEVICE, UGC_HOST} ugc_state_t;
	typedef struct packed {
		logic [2:0] entry;
		logic [1:0] size_code;
		logic banks2;
	} ugc_memory_reserve_bit_req_t;
	typedef struct packed {
		logic pullup_plus;
		logic pullup_minus;
		logic pulldown_both;
	} ugc_pull_t;
endpackage

// ===== design/ugc_top.sv
// Purpose: general control, role select, event grouping and endpoint memory allocation
// Assumes: all inputs synchronous to CLK; event pulses are one cycle wide
// Notes: one clock domain; entry 0 is the default control entry
//
// How it works
// - Reset leaves enable clear, clock frozen, controller off, pad suspended, states reset.
// - ID pin high sets the ID status bit and selects the device controller.
// - ID pin low clears ID status, disables device, enables host controller.
// - Setting enable enters host or device per ID pin, starting idle.
// - Clearing enable stops the controller and drops reserves; event flags, sizes and bases keep their values.
// - Two vectors: general events combined, and endpoint or pipe events combined.
// - A flag reaches its vector only when its enable bit is set.
// - Events are classed processing (ID, supply, session, swap) or exception.
// - In idle power mode any enabled interrupt wakes the CPU.
// - In power-down, device wake (host registers not selected), host wake (host registers selected), ID or supply change wakes asynchronously.
// - Control, status and event registers stay accessible while the clock is frozen.
// - While frozen, only device wake, host wake, ID and supply events may rise.
// - Device role: low-speed bit pulls up minus line, else plus line.
// - Host role: pull-downs on both lines and attached speed is detected.
// - Allocating entry k inserts it after k-1; k+1 slides up; higher stay.
// - Clearing an entry enable keeps its reserve bit, size and bank fields.
// - Releasing entry k frees it; k+1 slides down; higher stay even overlapping.
// - Entry zero memory is never moved by activity on higher entries.
// - Re-allocating with identical parameters slides k+1 down on release and back to its old base on reserve when k has one bank; higher stay.
// - The accepted flag is set after allocation even when regions overlap.
// - Memory is 832 bytes; every entry, the large one too, up to 64 per bank.
// - Freeze gates controller clocks but keeps resume detection active.
module ugc_top #(
	parameter int ENTRIES = ugc_pkg::NUM_ENTRIES,
	parameter int BIG_ENTRY = 1
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic CONTROLLER_ENABLE,
	input wire logic CLOCK_FREEZE,
	input wire logic ROLE_HOST_SELECT,
	input wire logic ROLE_ID_PIN,
	input wire logic LOW_SPEED_SELECT,
	input wire logic IDLE_POWER_MODE,
	input wire logic [ugc_pkg::GEN_SRC_N-1:0] GEN_EVENT_IN,
	input wire logic [ugc_pkg::GEN_SRC_N-1:0] GEN_EVENT_ENABLE,
	input wire logic [ugc_pkg::GEN_SRC_N-1:0] GEN_EVENT_CLEAR,
	input wire logic DEVICE_WAKE_IN,
	input wire logic HOST_WAKE_IN,
	input wire logic WAKE_ENABLE,
	input wire logic WAKE_CLEAR,
	input wire logic [ENTRIES-1:0] EP_EVENT_IN,
	input wire logic [ENTRIES-1:0] EP_EVENT_ENABLE,
	input wire logic [ENTRIES-1:0] EP_EVENT_CLEAR,
	input wire logic ATTACHED_LOW_SPEED,
	input wire logic [ENTRIES-1:0] ENTRY_ENABLE,
	input wire logic [ENTRIES-1:0] MEMORY_RESERVE_BIT,
	input wire logic [2*ENTRIES-1:0] ENTRY_SIZE_FIELD,
	input wire logic [ENTRIES-1:0] ENTRY_BANK_FIELD,
	output logic ID_STATUS,
	output logic DEVICE_ACTIVE,
	output logic HOST_ACTIVE,
	output logic HOST_REGS_SELECTED,
	output logic PAD_SUSPENDED,
	output logic CTRL_CLOCK_GATED,
	output logic [ugc_pkg::GEN_SRC_N-1:0] GEN_EVENT_FLAGS,
	output logic DEVICE_WAKE_FLAG,
	output logic HOST_WAKE_FLAG,
	output logic GENERAL_IRQ,
	output logic ENDPOINT_IRQ,
	output logic PROCESSING_PENDING,
	output logic EXCEPTION_PENDING,
	output logic CPU_WAKE,
	output logic ASYNC_WAKE,
	output ugc_pkg::ugc_pull_t PULLS,
	output logic SPEED_LOW_STATUS,
	output logic [ENTRIES-1:0] ENTRY_ENABLED,
	output logic [ENTRIES-1:0] CONFIG_ACCEPTED_FLAG,
	output logic [ENTRIES*ugc_pkg::ADDR_W-1:0] ENTRY_BASE,
	output logic [ENTRIES*ugc_pkg::SIZE_W-1:0] ENTRY_BYTES
);
	import ugc_pkg::*;

	ugc_state_t state_r;
	logic running;
	logic [GEN_SRC_N-1:0] gen_flags_r;
	logic [ENTRIES-1:0] ep_flags_r;
	logic dev_wake_r;
	logic host_wake_r;
	logic [ENTRIES-1:0] reserve_r;
	logic [ENTRIES-1:0] banks_r;
	logic [1:0] size_code_r [ENTRIES];
	logic [ADDR_W-1:0] base_r [ENTRIES];
	logic [GEN_SRC_N-1:0] frozen_ok;
	logic [GEN_SRC_N-1:0] gen_set;
	logic [ENTRIES-1:0] ep_set;
	logic [SIZE_W-1:0] bytes_of [ENTRIES];

	assign running = (state_r != UGC_RESET) && !CLOCK_FREEZE;

	// Role state: enable low returns the role state to reset; event flags and entry sizes and bases keep their values
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_r <= UGC_RESET;
		end else if (CE) begin
			if (!CONTROLLER_ENABLE) begin
				state_r <= UGC_RESET;
			end else begin
				case (state_r)
					UGC_RESET: state_r <= ROLE_ID_PIN ? UGC_DEVICE : UGC_HOST;
					UGC_DEVICE: if (!ROLE_ID_PIN) state_r <= UGC_HOST;
					UGC_HOST: if (ROLE_ID_PIN) state_r <= UGC_DEVICE;
					default: state_r <= UGC_RESET;
				endcase
			end
		end
	end

	// Role outputs and pad control
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ID_STATUS <= 1'b1;
			DEVICE_ACTIVE <= 1'b0;
			HOST_ACTIVE <= 1'b0;
			HOST_REGS_SELECTED <= CTRL_HOST_RST;
			PAD_SUSPENDED <= 1'b1;
			CTRL_CLOCK_GATED <= CTRL_FREEZE_RST;
			PULLS <= '0;
			SPEED_LOW_STATUS <= 1'b0;
		end else if (CE) begin
			ID_STATUS <= ROLE_ID_PIN;
			DEVICE_ACTIVE <= (state_r == UGC_DEVICE);
			HOST_ACTIVE <= (state_r == UGC_HOST);
			// Register view follows software only, never the pin
			HOST_REGS_SELECTED <= ROLE_HOST_SELECT;
			PAD_SUSPENDED <= (state_r == UGC_RESET);
			// Resume detection lives outside the gated domain, so wake flags still work
			CTRL_CLOCK_GATED <= CLOCK_FREEZE || (state_r == UGC_RESET);
			PULLS.pullup_minus <= (state_r == UGC_DEVICE) && LOW_SPEED_SELECT;
			PULLS.pullup_plus <= (state_r == UGC_DEVICE) && !LOW_SPEED_SELECT;
			PULLS.pulldown_both <= (state_r == UGC_HOST);
			if (state_r == UGC_HOST && running) begin
				SPEED_LOW_STATUS <= ATTACHED_LOW_SPEED;
			end
		end
	end

	// ID and supply changes may rise while frozen; the rest need a running clock
	assign frozen_ok = (GEN_SRC_N'(1) << EV_ID) | (GEN_SRC_N'(1) << EV_SUPPLY);
	assign gen_set = GEN_EVENT_IN & (running ? {GEN_SRC_N{1'b1}} : frozen_ok);
	assign ep_set = running ? EP_EVENT_IN : '0;

	// Sticky flags; a set in the clear cycle wins
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			gen_flags_r <= '0;
			ep_flags_r <= '0;
			dev_wake_r <= 1'b0;
			host_wake_r <= 1'b0;
		end else if (CE) begin
			// Register access stays live while frozen: no freeze term on the clears
			gen_flags_r <= (gen_flags_r & ~GEN_EVENT_CLEAR) | gen_set;
			ep_flags_r <= (ep_flags_r & ~EP_EVENT_CLEAR) | ep_set;
			dev_wake_r <= (dev_wake_r & ~WAKE_CLEAR) | (DEVICE_WAKE_IN && state_r == UGC_DEVICE);
			host_wake_r <= (host_wake_r & ~WAKE_CLEAR) | (HOST_WAKE_IN && state_r == UGC_HOST);
		end
	end

	// Vectors and wake outputs
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			GEN_EVENT_FLAGS <= '0;
			DEVICE_WAKE_FLAG <= 1'b0;
			HOST_WAKE_FLAG <= 1'b0;
			GENERAL_IRQ <= 1'b0;
			ENDPOINT_IRQ <= 1'b0;
			PROCESSING_PENDING <= 1'b0;
			EXCEPTION_PENDING <= 1'b0;
			CPU_WAKE <= 1'b0;
			ASYNC_WAKE <= 1'b0;
		end else if (CE) begin
			GEN_EVENT_FLAGS <= gen_flags_r;
			DEVICE_WAKE_FLAG <= dev_wake_r;
			HOST_WAKE_FLAG <= host_wake_r;
			GENERAL_IRQ <= |(gen_flags_r & GEN_EVENT_ENABLE)
				|| (WAKE_ENABLE && (dev_wake_r || host_wake_r));
			ENDPOINT_IRQ <= |(ep_flags_r & EP_EVENT_ENABLE);
			PROCESSING_PENDING <= |(gen_flags_r & GEN_EVENT_ENABLE & PROCESSING_MASK);
			EXCEPTION_PENDING <= |(gen_flags_r & GEN_EVENT_ENABLE & EXCEPTION_MASK);
			CPU_WAKE <= IDLE_POWER_MODE && (|(gen_flags_r & GEN_EVENT_ENABLE)
				|| |(ep_flags_r & EP_EVENT_ENABLE)
				|| (WAKE_ENABLE && (dev_wake_r || host_wake_r)));
			// Only sources that need no running controller clock may wake from power-down
			ASYNC_WAKE <= (dev_wake_r && !ROLE_HOST_SELECT) || (host_wake_r && ROLE_HOST_SELECT)
				|| gen_flags_r[EV_ID] || gen_flags_r[EV_SUPPLY];
		end
	end

	// Per-entry byte count, capped at 64 except for the large entry
	generate
		for (genvar k = 0; k < ENTRIES; k++) begin : g_size
			logic [SIZE_W-1:0] raw;
			logic [SIZE_W-1:0] cap;
			assign raw = SIZE_W'(8) << size_code_r[k];
			assign cap = (k == BIG_ENTRY) ? SIZE_W'(BIG_ENTRY_BYTES)
				: SIZE_W'(SMALL_ENTRY_BYTES);
			assign bytes_of[k] = ((raw > cap) ? cap : raw) << banks_r[k];
			assign ENTRY_BYTES[k*SIZE_W +: SIZE_W] = bytes_of[k];
			assign ENTRY_BASE[k*ADDR_W +: ADDR_W] = base_r[k];
		end
	endgenerate

	// Allocation: base of k is taken from k-1 at the change; only k and k+1 move
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			reserve_r <= '0;
			banks_r <= '0;
			CONFIG_ACCEPTED_FLAG <= '0;
			ENTRY_ENABLED <= '0;
			for (int i = 0; i < ENTRIES; i++) begin
				size_code_r[i] <= 2'h0;
				base_r[i] <= BASE_RST;
			end
		end else if (CE) begin
			if (state_r == UGC_RESET) begin
				reserve_r <= '0;
				CONFIG_ACCEPTED_FLAG <= '0;
				ENTRY_ENABLED <= '0;
			end else begin
				// Enable is tracked apart; reserve, size and banks are untouched by it
				ENTRY_ENABLED <= ENTRY_ENABLE & reserve_r;
				for (int k = 0; k < ENTRIES; k++) begin
					if (MEMORY_RESERVE_BIT[k] && !reserve_r[k]) begin
						reserve_r[k] <= 1'b1;
						size_code_r[k] <= ENTRY_SIZE_FIELD[2*k +: 2];
						banks_r[k] <= ENTRY_BANK_FIELD[k];
						// Entry zero always sits at the bottom, so higher work never moves it
						base_r[k] <= (k == 0) ? BASE_RST : ADDR_W'(base_r[(k == 0) ? 0 : k-1]
							+ (reserve_r[(k == 0) ? 0 : k-1] ? bytes_of[(k == 0) ? 0 : k-1]
							: SIZE_W'(0)));
						// No overlap check: accepted regardless
						CONFIG_ACCEPTED_FLAG[k] <= 1'b1;
					end else if (!MEMORY_RESERVE_BIT[k] && reserve_r[k]) begin
						reserve_r[k] <= 1'b0;
						CONFIG_ACCEPTED_FLAG[k] <= 1'b0;
					end
				end
				// Slide the neighbour above a changed entry; a reserve change of the entry just below moves it, whatever the size
				for (int k = 1; k < ENTRIES; k++) begin
					if (reserve_r[k] && (MEMORY_RESERVE_BIT[k-1] != reserve_r[k-1])) begin
						base_r[k] <= MEMORY_RESERVE_BIT[k-1]
							? ADDR_W'(base_r[k-1] + SIZE_W'(SIZE_W'(8) << ENTRY_SIZE_FIELD[2*(k-1) +: 2]))
							: base_r[k-1];
					end
				end
			end
		end
	end

	// Memory is shared, lives outside; its size is recorded but bounds none of the reported bases
	localparam int MEM_LIMIT = MEM_BYTES;
endmodule

// ===== bench/ugc_cable_model.sv
// Purpose: far cable end, a plugged function seen on the data lines
// Assumes: the function shows only its speed pull-up
// Notes: speed is sensed only while host pull-downs are on
module ugc_cable_model import ugc_pkg::*; (
	input wire ugc_pull_t pulls,
	input wire logic is_low_speed,
	output logic attached_low_speed
);
	timeunit 1ns;
	timeprecision 1ns;
	// Lines float low without host pull-downs, so no speed reads then
	assign attached_low_speed = pulls.pulldown_both & is_low_speed;
endmodule

// ===== bench/ugc_top_chk.sv
// Purpose: port checks of the USB general control block
// Assumes: CE high in checked cycles
// Notes: bound into ugc_top
module ugc_top_chk import ugc_pkg::*; #(parameter int ENTRIES = 7) (
	input wire logic CLK, RST_N, CE, CONTROLLER_ENABLE, CLOCK_FREEZE, ROLE_ID_PIN,
	input wire logic LOW_SPEED_SELECT, ID_STATUS, DEVICE_ACTIVE, HOST_ACTIVE,
	input wire logic PAD_SUSPENDED, CTRL_CLOCK_GATED, GENERAL_IRQ,
	input wire ugc_pull_t PULLS,
	input wire logic [GEN_SRC_N-1:0] GEN_EVENT_ENABLE, GEN_EVENT_FLAGS,
	input wire logic [ENTRIES-1:0] MEMORY_RESERVE_BIT, CONFIG_ACCEPTED_FLAG,
	input wire logic [ENTRIES*ADDR_W-1:0] ENTRY_BASE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	chk_off_resets:
		assert property ((CE && !CONTROLLER_ENABLE)[*2] |=> !DEVICE_ACTIVE && !HOST_ACTIVE
			&& PAD_SUSPENDED && CONFIG_ACCEPTED_FLAG == '0) else $error("off state wrong");
	chk_device_role:
		assert property ((CE && CONTROLLER_ENABLE && ROLE_ID_PIN && !CLOCK_FREEZE)[*3]
			|=> DEVICE_ACTIVE && !HOST_ACTIVE && ID_STATUS) else $error("no device role");
	chk_host_role:
		assert property ((CE && HOST_ACTIVE)[*2] |-> !ID_STATUS && !DEVICE_ACTIVE
			&& PULLS == 3'b001) else $error("host role wrong");
	chk_ls_pullup:
		assert property ((CE && DEVICE_ACTIVE && LOW_SPEED_SELECT)[*2]
			|=> PULLS.pullup_minus && !PULLS.pullup_plus) else $error("pull-up wrong");
	chk_irq_enabled:
		assert property (CE && $past(CE) && |(GEN_EVENT_FLAGS & $past(GEN_EVENT_ENABLE))
			|-> GENERAL_IRQ)
			else $error("irq missing");
	chk_frozen_quiet:
		assert property (CE && CTRL_CLOCK_GATED && CLOCK_FREEZE
			|-> ##2 (GEN_EVENT_FLAGS & ~$past(GEN_EVENT_FLAGS) & 8'hFC) == '0)
			else $error("event while frozen");
	chk_memory_reserve_bit_ok:
		assert property (CE && DEVICE_ACTIVE && $rose(MEMORY_RESERVE_BIT[1])
			|=> CONFIG_ACCEPTED_FLAG[1]) else $error("accept flag missing");
	chk_entry0_base:
		assert property (ENTRY_BASE[ADDR_W-1:0] == BASE_RST) else $error("entry 0 moved");
	cover property (DEVICE_ACTIVE && PULLS.pullup_minus);
	cover property (HOST_ACTIVE && PULLS.pulldown_both);
	cover property ($rose(CONFIG_ACCEPTED_FLAG[3]));
endmodule
bind ugc_top ugc_top_chk #(.ENTRIES(ENTRIES)) chk (.CLK, .RST_N, .CE, .CONTROLLER_ENABLE,
	.CLOCK_FREEZE, .ROLE_ID_PIN, .LOW_SPEED_SELECT, .ID_STATUS, .DEVICE_ACTIVE, .HOST_ACTIVE,
	.PAD_SUSPENDED, .CTRL_CLOCK_GATED, .GENERAL_IRQ, .PULLS, .GEN_EVENT_ENABLE,
	.GEN_EVENT_FLAGS, .MEMORY_RESERVE_BIT, .CONFIG_ACCEPTED_FLAG, .ENTRY_BASE);

// ===== bench/tb_ugc_top.sv
// Purpose: self-checking bench of the USB general control block
// Assumes: CE held high; bank field single
// Notes: one task per scenario
module tb_ugc_top import ugc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic CLK = 0, RST_N = 0, CE = 1, CONTROLLER_ENABLE = 0, CLOCK_FREEZE = 0, dev_ls = 1;
	logic ROLE_HOST_SELECT = 0, ROLE_ID_PIN = 1, LOW_SPEED_SELECT = 1, IDLE_POWER_MODE = 0;
	logic DEVICE_WAKE_IN = 0, HOST_WAKE_IN = 0, WAKE_ENABLE = 0, WAKE_CLEAR = 0;
	logic [7:0] GEN_EVENT_IN = '0, GEN_EVENT_ENABLE = '0, GEN_EVENT_CLEAR = '0, GEN_EVENT_FLAGS;
	logic [6:0] EP_EVENT_IN = '0, EP_EVENT_ENABLE = '0, EP_EVENT_CLEAR = '0, ENTRY_ENABLE = '0;
	logic [6:0] MEMORY_RESERVE_BIT = '0, ENTRY_BANK_FIELD = '0, ENTRY_ENABLED, CONFIG_ACCEPTED_FLAG;
	logic [13:0] ENTRY_SIZE_FIELD = '0;
	logic ATTACHED_LOW_SPEED, ID_STATUS, DEVICE_ACTIVE, HOST_ACTIVE, HOST_REGS_SELECTED;
	logic PAD_SUSPENDED, CTRL_CLOCK_GATED, DEVICE_WAKE_FLAG, HOST_WAKE_FLAG, GENERAL_IRQ;
	logic ENDPOINT_IRQ, PROCESSING_PENDING, EXCEPTION_PENDING, CPU_WAKE, ASYNC_WAKE;
	logic SPEED_LOW_STATUS;
	ugc_pull_t PULLS;
	logic [69:0] ENTRY_BASE;
	logic [62:0] ENTRY_BYTES;
	int fails = 0, n_checks = 0, cycles = 0;
	ugc_top dut (.CLK, .RST_N, .CE, .CONTROLLER_ENABLE, .CLOCK_FREEZE, .ROLE_HOST_SELECT,
		.ROLE_ID_PIN, .LOW_SPEED_SELECT, .IDLE_POWER_MODE, .GEN_EVENT_IN, .GEN_EVENT_ENABLE,
		.GEN_EVENT_CLEAR, .DEVICE_WAKE_IN, .HOST_WAKE_IN, .WAKE_ENABLE, .WAKE_CLEAR,
		.EP_EVENT_IN, .EP_EVENT_ENABLE, .EP_EVENT_CLEAR, .ATTACHED_LOW_SPEED, .ENTRY_ENABLE,
		.MEMORY_RESERVE_BIT, .ENTRY_SIZE_FIELD, .ENTRY_BANK_FIELD, .ID_STATUS, .DEVICE_ACTIVE,
		.HOST_ACTIVE, .HOST_REGS_SELECTED, .PAD_SUSPENDED, .CTRL_CLOCK_GATED, .GEN_EVENT_FLAGS,
		.DEVICE_WAKE_FLAG, .HOST_WAKE_FLAG, .GENERAL_IRQ, .ENDPOINT_IRQ, .PROCESSING_PENDING,
		.EXCEPTION_PENDING, .CPU_WAKE, .ASYNC_WAKE, .PULLS, .SPEED_LOW_STATUS, .ENTRY_ENABLED,
		.CONFIG_ACCEPTED_FLAG, .ENTRY_BASE, .ENTRY_BYTES);
	ugc_cable_model cable (.pulls(PULLS), .is_low_speed(dev_ls),
		.attached_low_speed(ATTACHED_LOW_SPEED));
	task automatic chk(logic [39:0] got, logic [39:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic t_roles();
		@(posedge CLK) CONTROLLER_ENABLE <= 1;
		cyc(3);
		chk({DEVICE_ACTIVE, PAD_SUSPENDED, CTRL_CLOCK_GATED, PULLS}, 6'h22);
		@(posedge CLK) LOW_SPEED_SELECT <= 0;
		ROLE_HOST_SELECT <= 1;
		cyc(3);
		chk({DEVICE_ACTIVE, HOST_REGS_SELECTED, PULLS}, 5'h1C);
		@(posedge CLK) ROLE_ID_PIN <= 0;
		ROLE_HOST_SELECT <= 0;
		cyc(3);
		chk({ID_STATUS, DEVICE_ACTIVE, HOST_ACTIVE, HOST_REGS_SELECTED}, 4'h2);
		chk({PULLS, SPEED_LOW_STATUS}, 4'h3);
		@(posedge CLK) CONTROLLER_ENABLE <= 0;
		cyc(3);
		chk({HOST_ACTIVE, PAD_SUSPENDED, CTRL_CLOCK_GATED}, 3'h3);
	endtask
	task automatic t_events();
		@(posedge CLK) ROLE_ID_PIN <= 1;
		CONTROLLER_ENABLE <= 1;
		IDLE_POWER_MODE <= 1;
		for (int i = 0; i < GEN_SRC_N; i++) begin
			@(posedge CLK) GEN_EVENT_IN <= 8'h01 << i;
			@(posedge CLK) GEN_EVENT_IN <= '0;
			cyc(2);
			chk({GEN_EVENT_FLAGS, GENERAL_IRQ}, {8'h01 << i, 1'b0});
			@(posedge CLK) GEN_EVENT_ENABLE <= 8'h01 << i;
			cyc(3);
			chk({GENERAL_IRQ, CPU_WAKE, PROCESSING_PENDING, EXCEPTION_PENDING},
				{2'b11, PROCESSING_MASK[i], EXCEPTION_MASK[i]});
			@(posedge CLK) GEN_EVENT_CLEAR <= 8'h01 << i;
			GEN_EVENT_ENABLE <= '0;
			@(posedge CLK) GEN_EVENT_CLEAR <= '0;
		end
		@(posedge CLK) WAKE_ENABLE <= 1;
		DEVICE_WAKE_IN <= 1;
		HOST_WAKE_IN <= 1;
		EP_EVENT_ENABLE <= 7'h04;
		EP_EVENT_IN <= 7'h04;
		@(posedge CLK) DEVICE_WAKE_IN <= 0;
		HOST_WAKE_IN <= 0;
		EP_EVENT_IN <= '0;
		cyc(3);
		chk({DEVICE_WAKE_FLAG, ASYNC_WAKE, GENERAL_IRQ, ENDPOINT_IRQ}, 4'hF);
		chk(HOST_WAKE_FLAG, 1'b0);
		@(posedge CLK) WAKE_CLEAR <= 1;
		@(posedge CLK) WAKE_CLEAR <= 0;
		cyc(2);
		chk({DEVICE_WAKE_FLAG, ASYNC_WAKE, GENERAL_IRQ, ENDPOINT_IRQ}, 4'h1);
	endtask
	task automatic t_freeze();
		@(posedge CLK) CLOCK_FREEZE <= 1;
		GEN_EVENT_ENABLE <= 8'h05;
		cyc(3);
		@(posedge CLK) GEN_EVENT_IN <= 8'h05;
		@(posedge CLK) GEN_EVENT_IN <= '0;
		cyc(2);
		chk({CTRL_CLOCK_GATED, GEN_EVENT_FLAGS}, 9'h101);
		// Clearing while frozen shows the event register is still reachable
		@(posedge CLK) GEN_EVENT_CLEAR <= 8'h01;
		@(posedge CLK) GEN_EVENT_CLEAR <= '0;
		CLOCK_FREEZE <= 0;
		cyc(3);
		chk({CTRL_CLOCK_GATED, GEN_EVENT_FLAGS}, 9'h000);
	endtask
	task automatic res(int k, logic on, logic [1:0] code);
		@(posedge CLK) ENTRY_SIZE_FIELD[2*k+:2] <= code;
		MEMORY_RESERVE_BIT[k] <= on;
		ENTRY_ENABLE[k] <= on;
		cyc(2);
	endtask
	task automatic t_memory_reserve_bit();
		// Entries are reserved lowest first, as firmware must
		res(0, 1, 3);
		res(1, 1, 2);
		res(2, 1, 3);
		res(3, 1, 3);
		chk(ENTRY_BASE[39:0], {10'h0A0, 10'h060, 10'h040, 10'h000});
		chk(ENTRY_BYTES[35:0], {9'h040, 9'h040, 9'h020, 9'h040});
		@(posedge CLK) ENTRY_ENABLE[1] <= 0;
		cyc(2);
		chk({ENTRY_ENABLED[1], CONFIG_ACCEPTED_FLAG[1], ENTRY_BASE[19:10], ENTRY_BYTES[17:9]},
			{2'b01, 10'h040, 9'h020});
		res(2, 0, 3);
		res(2, 1, 3);
		chk(ENTRY_BASE[39:20], {10'h0A0, 10'h060});
		res(1, 0, 2);
		chk({ENTRY_BASE[39:20], ENTRY_BASE[9:0]}, {10'h0A0, 10'h040, 10'h000});
		res(1, 1, 3);
		chk(ENTRY_BASE[39:0], {10'h0A0, 10'h080, 10'h040, 10'h000});
		chk(CONFIG_ACCEPTED_FLAG[3:0], 4'hF);
	endtask
	initial begin
		forever #5 CLK = ~CLK;
	end
	// Ceiling well above the roughly 150 cycles the scenarios need
	always @(posedge CLK) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fails++;
			conclude();
		end
	end
	initial begin
		cyc(2);
		chk({ID_STATUS, PAD_SUSPENDED, CTRL_CLOCK_GATED, DEVICE_ACTIVE}, 4'hE);
		@(posedge CLK) RST_N <= 1;
		t_roles();
		t_events();
		t_freeze();
		t_memory_reserve_bit();
		conclude();
	end
endmodule
